// ---- hbic_host_model.sv ----
// Host processor model driving the bus pins of the interface block
`timescale 1ns/1ns
module hbic_host_model (
    input  wire logic        clk_sys,           // System clock
    input  wire logic        srdy_pin,          // Sync ready as seen
    input  wire logic        async_ready_out_pin,          // Async ready with pull-up
    output logic             bus_clk,           // Host bus clock
    output logic             addr_qualifier,    // Qualifier, low
    output logic [15:1]      addr_word_bits,    // Address pins
    output logic             read_strobe_low,   // Read strobe
    output logic             write_strobe_low,  // Write strobe
    output logic             cycle_phase_low,   // Cycle signal
    output logic             ready_return_low,  // Ready return
    output logic             sync_write_read,   // Direction
    output logic             addr_latch_strobe  // Address strobe
);
    logic run;
    logic seen;
    int   n;

    // Idle pin levels; bus clock still outside accesses
    initial begin
        run = 1'b0;
        {addr_qualifier, read_strobe_low, write_strobe_low} = 3'h7;
        {cycle_phase_low, ready_return_low, addr_latch_strobe} = 3'h7;
        {sync_write_read, bus_clk, addr_word_bits} = 17'h00000;
        #7;
        // 160 ns period, well under the ceiling
        forever #80 bus_clk = run ? ~bus_clk : 1'b0;
    end

    // Parks an address and qualifier for the decode check
    task automatic drive_addr(input logic [15:1] a, input logic q);
        addr_word_bits <= a;
        addr_qualifier <= q;
    endtask

    // Strobe access, held until async ready returns high
    task automatic async_acc(input logic wr, input logic [15:1] a, output logic ok);
        @(posedge clk_sys);
        addr_word_bits <= a;
        addr_qualifier <= 1'b0;
        @(posedge clk_sys);
        if (wr)
            write_strobe_low <= 1'b0;
        else
            read_strobe_low <= 1'b0;
        for (n = 0; n < 40 && async_ready_out_pin !== 1'b0; n++) @(posedge clk_sys);
        seen = (async_ready_out_pin === 1'b0);
        for (n = 0; n < 400 && async_ready_out_pin !== 1'b1; n++) @(posedge clk_sys);
        ok = seen && async_ready_out_pin === 1'b1;
        addr_qualifier <= 1'b1;
        addr_word_bits <= ~a;
        {read_strobe_low, write_strobe_low} <= 2'h3;
    endtask

    // Local-bus or burst access on the bus clock
    task automatic sync_acc(input logic burst, input logic wr, input logic [15:1] a,
                            output logic ok);
        run = 1'b1;
        @(posedge bus_clk);
        addr_word_bits <= a;
        addr_qualifier <= 1'b0;
        addr_latch_strobe <= ~burst;
        // direction on its pin, burst cycle high reads
        sync_write_read <= wr;
        cycle_phase_low <= burst ? ~wr : 1'b1;
        @(posedge bus_clk);
        addr_latch_strobe <= 1'b1;
        // cycle signal follows the address phase
        if (!burst)
            cycle_phase_low <= 1'b0;
        for (n = 0; n < 30 && srdy_pin !== 1'b0; n++) @(posedge bus_clk);
        seen = (srdy_pin === 1'b0);
        for (n = 0; n < 30 && burst && srdy_pin !== 1'b1; n++) @(posedge bus_clk);
        ok = seen && (!burst || srdy_pin === 1'b1);
        addr_qualifier <= 1'b1;
        addr_word_bits <= ~a;
        cycle_phase_low <= 1'b1;
        // ready return completes a local read
        ready_return_low <= burst | wr;
        @(posedge bus_clk);
        ready_return_low <= 1'b1;
        repeat (2) @(posedge bus_clk);
        run = 1'b0;
    endtask
endmodule

// ---- hbic_pkg.sv ----
// Constants and types for the host bus interface control block
package hbic_pkg;
    // Address field positions
    localparam int ADDR_HI = 15;
    localparam int ADDR_LO = 1;
    localparam int DEC_LO  = 4;
    // Fastest host bus clock accepted in synchronous modes
    localparam int BUS_CLK_MAX_MHZ = 50;
    // Cycles of settling before the strap is caught
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    // Reset values of the ready outputs
    localparam logic SRDY_RST = 1'b1;
    localparam logic OE_RST   = 1'b1;
    // Bit positions in the synchroniser vector
    localparam int SI_BCLK  = 0;
    localparam int SI_STRAP = 1;
    localparam int SI_QUAL  = 2;
    localparam int SI_RD    = 3;
    localparam int SI_WR    = 4;
    localparam int SI_CYC   = 5;
    localparam int SI_RRET  = 6;
    localparam int SI_SWR   = 7;
    localparam int SI_ADS   = 8;
    localparam int SI_ADDR  = 9;
    localparam int SYNC_W   = 24;
    typedef enum logic [1:0] {MODE_LOCAL, MODE_ASYNC, MODE_BURST} hbic_mode_t;
    typedef enum logic [2:0] {
        ST_IDLE, ST_CORE, ST_RDY_LOW, ST_RDY_HIGH, ST_RETURN, ST_STROBE_END
    } hbic_state_t;
endpackage

// ---- hbic_top.sv ----
// Host bus interface control: decode, ready and wait signalling, strap mode
`timescale 1ns/1ns
module hbic_top
    import hbic_pkg::*;
#(
    parameter int IRQ_W = 8
) (
    input  wire logic               clk_sys,            // System clock
    input  wire logic               rst,                // Sync reset, high
    input  wire logic               bus_clk,            // Host bus clock pin
    input  wire logic               bus_style_strap,    // Bus style strap pin
    input  wire logic               addr_qualifier,     // Address qualifier, low
    input  wire logic [15:1]        addr_word_bits,     // Host address pins
    input  wire logic               read_strobe_low,    // Read strobe pin
    input  wire logic               write_strobe_low,   // Write strobe pin
    input  wire logic               cycle_phase_low,    // Cycle signal pin
    input  wire logic               ready_return_low,   // Ready return pin
    input  wire logic               sync_write_read,    // Sync direction pin
    input  wire logic               addr_latch_strobe,  // Address strobe pin
    input  wire logic [15:0]        base_addr,          // Programmed base address
    input  wire logic               burst_enable,       // Strap high: burst
    input  wire logic               addr_latch_en,      // Use latched address
    input  wire logic [IRQ_W-1:0]   irq_status,         // Interrupt status bits
    input  wire logic               acc_done,           // Core finished access
    output logic                    local_select_out,   // Select, active low
    output logic                    sync_ready_low,     // Sync ready pin
    output logic                    async_ready_out,    // Async ready drive value
    output logic                    async_ready_oe_low, // Async ready enable
    output logic                    irq_out_low,        // Interrupt drive value
    output logic                    irq_oe_low,         // Interrupt enable
    output logic                    acc_req,            // Access request pulse
    output logic                    acc_write,          // Access is write
    output logic [15:1]             acc_addr,           // Access word address
    output hbic_mode_t              bus_mode            // Selected bus style
);

    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] s1_q;
    logic [SYNC_W-1:0] s2_q;
    logic [15:1]       s_addr;

    // Gather the pins for synchronising
    assign raw = {addr_word_bits, addr_latch_strobe, sync_write_read,
                  ready_return_low, cycle_phase_low, write_strobe_low,
                  read_strobe_low, addr_qualifier, bus_style_strap, bus_clk};

    // Two-flop synchroniser per pin
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                end else begin
                    s1_q[gi] <= raw[gi];
                    s2_q[gi] <= s1_q[gi];
                end
            end
        end
    endgenerate

    assign s_addr = s2_q[SYNC_W-1:SI_ADDR];

    // qualifier low and upper bits match
    assign local_select_out = ~(~addr_qualifier &&
                                (addr_word_bits[ADDR_HI:DEC_LO] == base_addr[ADDR_HI:DEC_LO]));

    // Edge history and latched address
    logic          bclk_prev_q, ads_prev_q, strb_prev_q;
    logic [15:1]   lat_addr_q, lat_addr_d;
    logic          lat_qual_q, lat_qual_d;
    logic          bclk_rise, ads_rise, rd_act, wr_act, strb_act;
    logic [15:1]   cur_addr;
    logic          cur_qual, hit;

    assign bclk_rise = s2_q[SI_BCLK] & ~bclk_prev_q;
    assign ads_rise  = s2_q[SI_ADS] & ~ads_prev_q;
    assign rd_act    = ~s2_q[SI_RD];
    assign wr_act    = ~s2_q[SI_WR];
    assign strb_act  = rd_act | wr_act;

    // latch address and qualifier on strobe rise
    always_comb begin
        lat_addr_d = lat_addr_q;
        lat_qual_d = lat_qual_q;
        if (ads_rise) begin
            lat_addr_d = s_addr;
            lat_qual_d = s2_q[SI_QUAL];
        end
    end

    // Address seen by the access logic
    assign cur_addr = addr_latch_en ? lat_addr_q : s_addr;
    assign cur_qual = addr_latch_en ? lat_qual_q : s2_q[SI_QUAL];
    assign hit = ~cur_qual && (cur_addr[ADDR_HI:DEC_LO] == base_addr[ADDR_HI:DEC_LO]);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bclk_prev_q <= 1'b0;
            ads_prev_q  <= 1'b0;
            strb_prev_q <= 1'b0;
            lat_addr_q  <= '0;
            lat_qual_q  <= 1'b1;
        end else begin
            bclk_prev_q <= s2_q[SI_BCLK];
            ads_prev_q  <= s2_q[SI_ADS];
            strb_prev_q <= strb_act;
            lat_addr_q  <= lat_addr_d;
            lat_qual_q  <= lat_qual_d;
        end
    end

    // Strap capture after the synchroniser has settled
    logic [1:0]  settle_q, settle_d;
    logic        captured_q, captured_d;
    hbic_mode_t  mode_q, mode_d;

    always_comb begin
        settle_d   = settle_q;
        captured_d = captured_q;
        mode_d     = mode_q;
        if (!captured_q) begin
            if (settle_q == STRAP_SETTLE) begin
                captured_d = 1'b1;
                // strap high selects async or burst
                if (!s2_q[SI_STRAP])
                    mode_d = MODE_LOCAL;
                else
                    mode_d = burst_enable ? MODE_BURST : MODE_ASYNC;
            end else begin
                settle_d = settle_q + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            settle_q   <= 2'h0;
            captured_q <= 1'b0;
            mode_q     <= MODE_LOCAL;
        end else begin
            settle_q   <= settle_d;
            captured_q <= captured_d;
            mode_q     <= mode_d;
        end
    end

    assign bus_mode = mode_q;

    // Access sequencer
    hbic_state_t state_q, state_d;
    logic        srdy_q, srdy_d, async_ready_out_oe_q, async_ready_out_oe_d;
    logic        req_q, req_d, wr_q, wr_d;
    logic [15:1] aaddr_q, aaddr_d;

    always_comb begin
        state_d   = state_q;
        srdy_d    = srdy_q;
        async_ready_out_oe_d = async_ready_out_oe_q;
        req_d     = 1'b0;
        wr_d      = wr_q;
        aaddr_d   = aaddr_q;
        unique case (state_q)
            ST_IDLE: begin
                // nothing starts without a decode hit
                if (captured_q && hit) begin
                    if (mode_q == MODE_ASYNC && strb_act && !strb_prev_q) begin
                        req_d     = 1'b1;
                        wr_d      = wr_act;
                        aaddr_d   = cur_addr;
                        // stretch by pulling async ready low
                        async_ready_out_oe_d = 1'b0;
                        state_d   = ST_CORE;
                    end else if (mode_q == MODE_LOCAL && bclk_rise &&
                                 !s2_q[SI_CYC]) begin
                        req_d   = 1'b1;
                        wr_d    = s2_q[SI_SWR];
                        aaddr_d = cur_addr;
                        state_d = ST_CORE;
                    end else if (mode_q == MODE_BURST && bclk_rise &&
                                 !s2_q[SI_ADS]) begin
                        req_d   = 1'b1;
                        wr_d    = ~s2_q[SI_CYC];
                        aaddr_d = cur_addr;
                        // hold sync ready low for waits
                        srdy_d  = 1'b0;
                        state_d = ST_CORE;
                    end
                end
            end
            ST_CORE: begin
                if (acc_done) begin
                    if (mode_q == MODE_ASYNC) begin
                        async_ready_out_oe_d = 1'b1;
                        state_d   = ST_STROBE_END;
                    end else if (mode_q == MODE_LOCAL) begin
                        state_d = ST_RDY_LOW;
                    end else begin
                        state_d = ST_RDY_HIGH;
                    end
                end
            end
            ST_RDY_LOW: begin
                // falling edge tells the host it is done
                // moves only on a bus clock edge
                if (bclk_rise) begin
                    srdy_d  = 1'b0;
                    state_d = ST_RDY_HIGH;
                end
            end
            ST_RDY_HIGH: begin
                // release on the next bus clock edge
                if (bclk_rise) begin
                    srdy_d  = 1'b1;
                    state_d = (mode_q == MODE_LOCAL && !wr_q) ? ST_RETURN : ST_IDLE;
                end
            end
            ST_RETURN: begin
                if (!s2_q[SI_RRET])
                    state_d = ST_IDLE;
            end
            ST_STROBE_END: begin
                if (!strb_act)
                    state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q   <= ST_IDLE;
            srdy_q    <= SRDY_RST;
            async_ready_out_oe_q <= OE_RST;
            req_q     <= 1'b0;
            wr_q      <= 1'b0;
            aaddr_q   <= '0;
        end else begin
            state_q   <= state_d;
            srdy_q    <= srdy_d;
            async_ready_out_oe_q <= async_ready_out_oe_d;
            req_q     <= req_d;
            wr_q      <= wr_d;
            aaddr_q   <= aaddr_d;
        end
    end

    // Interrupt pin drive
    logic irq_oe_q, irq_oe_d;
    // drive low while any status bit set
    always_comb begin
        irq_oe_d = ~(|irq_status);
    end

    always_ff @(posedge clk_sys) begin
        if (rst)
            irq_oe_q <= OE_RST;
        else
            irq_oe_q <= irq_oe_d;
    end

    assign sync_ready_low     = srdy_q;
    assign async_ready_out    = 1'b0;
    assign async_ready_oe_low = async_ready_out_oe_q;
    assign irq_out_low        = 1'b0;
    assign irq_oe_low         = irq_oe_q;
    assign acc_req            = req_q;
    assign acc_write          = wr_q;
    assign acc_addr           = aaddr_q;

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    AST_LSEL_HIT: assert property (
        (!addr_qualifier && addr_word_bits[15:4] == base_addr[15:4]) |-> !local_select_out)
        else $error("select not asserted on match");
    AST_LSEL_MISS: assert property (
        addr_qualifier |-> local_select_out)
        else $error("select asserted with qualifier high");
    AST_SRDY_STEP: assert property (
        $changed(sync_ready_low) |-> $past(bclk_rise))
        else $error("sync ready moved off a bus clock edge");
    AST_LOCAL_FALL: assert property (
        ($fell(sync_ready_low) && mode_q == MODE_LOCAL) |-> $past(state_q == ST_RDY_LOW))
        else $error("local ready fall without completion");
    AST_BURST_WAIT: assert property (
        (mode_q == MODE_BURST && state_q == ST_CORE) |-> !sync_ready_low)
        else $error("burst wait not held low");
    AST_ASYNC_QUIET: assert property (
        (mode_q == MODE_ASYNC) |-> sync_ready_low)
        else $error("sync ready driven in async mode");
    AST_IRQ: assert property (
        (|irq_status) |=> !irq_oe_low)
        else $error("interrupt pin not pulled low");
    AST_ASYNC_READY_OUT: assert property (
        (mode_q == MODE_ASYNC && state_q == ST_CORE) |-> !async_ready_oe_low)
        else $error("async ready not stretching");
    AST_NO_HIT: assert property (
        (state_q == ST_IDLE && !hit) |=> !acc_req)
        else $error("access started without decode");
    AST_STRAP_LO: assert property (
        ($rose(captured_q) && !$past(s2_q[SI_STRAP])) |-> mode_q == MODE_LOCAL)
        else $error("strap low not local-bus");
    AST_STRAP_HI: assert property (
        ($rose(captured_q) && $past(s2_q[SI_STRAP])) |-> mode_q != MODE_LOCAL)
        else $error("strap high chose local-bus");
    AST_LATCH: assert property (
        ads_rise |=> lat_addr_q == $past(s_addr))
        else $error("address not latched");

    COV_LOCAL: cover property (mode_q == MODE_LOCAL && $fell(sync_ready_low));
    COV_BURST: cover property (mode_q == MODE_BURST && $rose(sync_ready_low));
    COV_ASYNC: cover property (mode_q == MODE_ASYNC && $rose(async_ready_oe_low));

endmodule

// ---- testbench.sv ----
// Self-checking bench for the host bus interface control block
`timescale 1ns/1ns
module testbench;
    import hbic_pkg::*;
    localparam logic [15:1] HIT  = 15'h1D28;
    localparam logic [15:1] MISS = 15'h5D28;
    logic        clk_sys, rst, bus_clk, bus_style_strap, addr_qualifier, read_strobe_low;
    logic        write_strobe_low, cycle_phase_low, ready_return_low, sync_write_read;
    logic        addr_latch_strobe, burst_enable, addr_latch_en, acc_done, local_select_out;
    logic        sync_ready_low, async_ready_out, async_ready_oe_low, irq_out_low, irq_oe_low;
    logic        acc_req, acc_write, ok, prev_srdy, prev_bclk;
    logic [15:1] addr_word_bits, acc_addr;
    logic [15:0] base_addr;
    logic [7:0]  irq_status;
    hbic_mode_t  bus_mode;
    int          n_errors, checks_done, cycles, req_count, srdy_falls, bad_changes, since_rise;
    wire         async_ready_out_wire = async_ready_oe_low ? 1'b1 : async_ready_out;
    wire         irq_wire = irq_oe_low ? 1'b1 : irq_out_low;

    // Device under test and host model
    hbic_top #(.IRQ_W(8)) dut (
        .clk_sys, .rst, .bus_clk, .bus_style_strap, .addr_qualifier, .addr_word_bits,
        .read_strobe_low, .write_strobe_low, .cycle_phase_low, .ready_return_low,
        .sync_write_read, .addr_latch_strobe, .base_addr, .burst_enable, .addr_latch_en,
        .irq_status, .acc_done, .local_select_out, .sync_ready_low, .async_ready_out,
        .async_ready_oe_low, .irq_out_low, .irq_oe_low, .acc_req, .acc_write, .acc_addr,
        .bus_mode
    );
    hbic_host_model host (
        .clk_sys, .srdy_pin(sync_ready_low), .async_ready_out_pin(async_ready_out_wire), .bus_clk,
        .addr_qualifier, .addr_word_bits, .read_strobe_low, .write_strobe_low,
        .cycle_phase_low, .ready_return_low, .sync_write_read, .addr_latch_strobe
    );

    // 50 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Request pulses, ready edges against bus clock rises, timeout
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        prev_bclk <= bus_clk;
        prev_srdy <= sync_ready_low;
        since_rise <= (bus_clk && !prev_bclk) ? 0 : since_rise + 1;
        if (acc_req === 1'b1) req_count <= req_count + 1;
        if (!rst && sync_ready_low !== prev_srdy) begin
            if (sync_ready_low === 1'b0) srdy_falls <= srdy_falls + 1;
            if (since_rise > 6) bad_changes <= bad_changes + 1;
        end
        if (cycles == 20000) begin
            n_errors++;
            give_verdict();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic do_reset(input logic strap, input logic burst);
        rst <= 1'b1;
        bus_style_strap <= strap;
        burst_enable <= burst;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask

    // Core side: take the request, stall, then finish
    task automatic core_answer(input logic wr, input logic [1:0] hold);
        for (int n = 0; n < 600 && acc_req !== 1'b1; n++) @(posedge clk_sys);
        check("acc_write", 16'(acc_write), 16'(wr));
        check("acc_addr", 16'(acc_addr), 16'(HIT));
        repeat (25) @(posedge clk_sys);
        check("ready held", 16'({sync_ready_low, async_ready_oe_low}), 16'(hold));
        acc_done <= 1'b1;
        @(posedge clk_sys);
        acc_done <= 1'b0;
    endtask

    // One hitting access of the given kind: 0 async, 1 local, 2 burst
    task automatic one_access(input logic [1:0] kind, input logic wr, input logic [1:0] hold);
        int r;
        int f;
        r = req_count;
        f = srdy_falls;
        fork
            if (kind == 2'h0) host.async_acc(wr, HIT, ok);
            else host.sync_acc(kind[1], wr, HIT, ok);
            core_answer(wr, hold);
        join
        check("ready handshake", 16'(ok), 16'h0001);
        check("requests", 16'(req_count - r), 16'h0001);
        check("ready falls", 16'(srdy_falls - f), 16'(kind != 2'h0));
        check("off-edge ready", 16'(bad_changes), 16'h0000);
    endtask

    task automatic t_decode();
        logic [15:1] av [5] = '{15'h1D28, 15'h1D2C, 15'h1D28, 15'h1D20, 15'h5D28};
        logic        qv [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
        logic        ev [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
        int          r;
        check("bus_mode", 16'(bus_mode), 16'(MODE_LOCAL));
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_sys);
            host.drive_addr(av[i], qv[i]);
            #1 check("local_select_out", 16'(local_select_out), 16'(ev[i]));
        end
        @(posedge clk_sys);
        host.drive_addr(MISS, 1'b1);
        r = req_count;
        host.sync_acc(1'b0, 1'b0, MISS, ok);
        check("miss ready", 16'(ok), 16'h0000);
        check("miss requests", 16'(req_count - r), 16'h0000);
        $display("decode test done");
    endtask

    task automatic t_local();
        one_access(2'h1, 1'b0, 2'h3);
        one_access(2'h1, 1'b1, 2'h3);
        $display("local-bus test done");
    endtask

    task automatic t_irq();
        logic [7:0] pv [4] = '{8'h00, 8'h01, 8'h80, 8'h00};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            irq_status <= pv[i];
            repeat (4) @(posedge clk_sys);
            check("irq pin", 16'(irq_wire), 16'(pv[i] == 8'h00));
        end
        $display("interrupt test done");
    endtask

    task automatic t_async();
        int r;
        do_reset(1'b1, 1'b0);
        check("bus_mode", 16'(bus_mode), 16'(MODE_ASYNC));
        one_access(2'h0, 1'b0, 2'h2);
        one_access(2'h0, 1'b1, 2'h2);
        r = req_count;
        host.async_acc(1'b0, MISS, ok);
        check("miss ready", 16'(ok), 16'h0000);
        check("miss requests", 16'(req_count - r), 16'h0000);
        $display("async test done");
    endtask

    task automatic t_burst();
        do_reset(1'b1, 1'b1);
        check("bus_mode", 16'(bus_mode), 16'(MODE_BURST));
        one_access(2'h2, 1'b0, 2'h1);
        one_access(2'h2, 1'b1, 2'h1);
        do_reset(1'b0, 1'b1);
        check("bus_mode", 16'(bus_mode), 16'(MODE_LOCAL));
        $display("burst test done");
    endtask

    // Main sequence
    initial begin
        {rst, bus_style_strap, burst_enable, addr_latch_en, acc_done} = 5'h10;
        base_addr = 16'h3A50;
        irq_status = 8'h00;
        {n_errors, checks_done, cycles, req_count} = 128'h0;
        {srdy_falls, bad_changes, since_rise} = 96'h0;
        do_reset(1'b0, 1'b0);
        t_decode();
        t_local();
        t_irq();
        t_async();
        t_burst();
        give_verdict();
    end
endmodule
